// file: modbus_slave_pkg.sv
// Constants shared by the Modbus slave query engine and its CRC unit
`default_nettype none

package modbus_slave_pkg;

  // ==========================================================
  // Function codes and exception encodings
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] FC_LOG = 8'h46;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] BCAST_ADDR = 8'h00;

  // ==========================================================
  // Frame layout, byte positions and lengths
  localparam logic [8:0] POS_SADDR = 9'h000;
  localparam logic [8:0] POS_FC = 9'h001;
  localparam logic [8:0] POS_START_HI = 9'h002;
  localparam logic [8:0] POS_START_LO = 9'h003;
  localparam logic [8:0] POS_CNT_HI = 9'h004;
  localparam logic [8:0] POS_CNT_LO = 9'h005;
  localparam logic [8:0] POS_BCNT = 9'h006;
  localparam logic [8:0] MIN_FRAME = 9'h004;
  localparam logic [8:0] LEN_LOG_QUERY = 9'h004;
  localparam logic [8:0] LEN_READ_QUERY = 9'h008;
  localparam logic [8:0] LEN_WRITE_HDR = 9'h009;
  localparam logic [8:0] LEN_ECHO = 9'h006;
  localparam logic [8:0] LEN_LOG_RSP = 9'h006;
  localparam logic [8:0] LEN_EXC = 9'h003;
  localparam logic [8:0] RD_DATA_BASE = 9'h003;
  localparam logic [8:0] WR_DATA_BASE = 9'h007;
  localparam logic [8:0] CRC_BYTES = 9'h002;
  localparam int BUF_DEPTH_DEF = 260;
  localparam int MAX_REGS_DEF = 125;

  // ==========================================================
  // CRC-16 (reflected polynomial, all-ones start, zero residue)
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

endpackage

`default_nettype wire

// file: modbus_crc16.sv
// Byte-serial CRC-16 accumulator for RTU frames
`default_nettype none

module modbus_crc16
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc
);
  import modbus_slave_pkg::*;

  logic [15:0] next_crc;

  always_comb
  begin
    next_crc = crc;
    if (clr)
    begin
      next_crc = CRC_INIT;
    end
    else if (en)
    begin
      next_crc = crc ^ {8'h00, din};
      for (int b = 0; b < 8; b++)
      begin
        next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      crc <= CRC_INIT;
    else
      crc <= next_crc;
  end

endmodule

`default_nettype wire

// file: modbus_slave_access_log.sv
// Modbus RTU slave query engine: write echo, access log, exception replies
`default_nettype none

module modbus_slave_access_log #(
  parameter int MAX_REGS = modbus_slave_pkg::MAX_REGS_DEF,
  parameter int BUF_DEPTH = modbus_slave_pkg::BUF_DEPTH_DEF,
  parameter int CNT_W = 16
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] station_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_fault,
  input wire logic rx_frame_end,
  output logic reg_req,
  output logic reg_write,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ok,
  input wire logic reg_value_bad,
  input wire logic [15:0] reg_rdata,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic busy,
  output logic [CNT_W-1:0] comm_error_count,
  output logic comm_error_output
);
  import modbus_slave_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_REQ, ST_WAIT, ST_RD_LO, ST_FINISH, ST_SEND}
    state_e;

  function automatic logic count_ok(input logic [15:0] n);
    count_ok = (n != 16'h0000) && (n <= 16'(MAX_REGS));
  endfunction

  // ==========================================================
  // State
  state_e state, next_state;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic buf_we;
  logic [8:0] buf_wa;
  logic [7:0] buf_wd;
  logic [8:0] len, next_len, tx_len, next_tx_len, tidx, next_tidx;
  logic drop, next_drop, rx_bad, next_rx_bad, bcast, next_bcast;
  logic [7:0] saddr, next_saddr, fc, next_fc, bcnt, next_bcnt, exc, next_exc;
  logic [7:0] rd_lo, next_rd_lo, idx, next_idx, pick, fin_exc;
  logic [15:0] start, next_start, cnt, next_cnt, first_ok, next_first_ok;
  logic [15:0] ok_cnt, next_ok_cnt, log_start, next_log_start, log_cnt, next_log_cnt;
  logic val_bad, next_val_bad, fault, for_me;
  logic next_reg_req, next_reg_write, next_tx_valid, next_comm_error_output, next_busy;
  logic [15:0] next_reg_addr, next_reg_wdata;
  logic [7:0] next_tx_byte;
  logic [CNT_W-1:0] next_comm_error_count;
  logic [15:0] rx_crc, tx_crc;
  logic tcrc_en;
  logic [8:0] wr_pos, rd_pos;

  modbus_crc16 u_rx_crc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clr(state == ST_CHECK),
    .en(buf_we && state == ST_IDLE),
    .din(rx_byte),
    .crc(rx_crc)
  );

  modbus_crc16 u_tx_crc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clr(state == ST_FINISH),
    .en(tcrc_en),
    .din(pick),
    .crc(tx_crc)
  );

  assign fault = rx_bad || (len < MIN_FRAME) || (rx_crc != CRC_RESIDUE);
  assign for_me = (saddr == station_addr) || (saddr == BCAST_ADDR);
  assign wr_pos = WR_DATA_BASE + {idx, 1'b0};
  assign rd_pos = RD_DATA_BASE + {idx, 1'b0};

  // ==========================================================
  // Reply byte selection
  always_comb
  begin
    pick = buf_mem[tidx];
    if (exc != EXC_NONE)
    begin
      if (tidx == POS_FC)
        pick = fc | EXC_FLAG;
      else if (tidx == POS_START_HI)
        pick = exc;
    end
    else if (fc == FC_LOG)
    begin
      case (tidx)
        POS_START_HI: pick = log_start[15:8];
        POS_START_LO: pick = log_start[7:0];
        POS_CNT_HI: pick = log_cnt[15:8];
        POS_CNT_LO: pick = log_cnt[7:0];
        default: pick = buf_mem[tidx];
      endcase
    end
    else if (fc == FC_READ && tidx == POS_START_HI)
      pick = {cnt[6:0], 1'b0};
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_state = state;
    next_len = len;
    next_drop = drop;
    next_rx_bad = rx_bad;
    next_bcast = bcast;
    next_saddr = saddr;
    next_fc = fc;
    next_start = start;
    next_cnt = cnt;
    next_bcnt = bcnt;
    next_exc = exc;
    next_idx = idx;
    next_rd_lo = rd_lo;
    next_first_ok = first_ok;
    next_ok_cnt = ok_cnt;
    next_val_bad = val_bad;
    next_log_start = log_start;
    next_log_cnt = log_cnt;
    next_tx_len = tx_len;
    next_tidx = tidx;
    next_reg_req = 1'b0;
    next_reg_write = reg_write;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_tx_valid = tx_valid;
    next_tx_byte = tx_byte;
    next_comm_error_count = comm_error_count;
    next_comm_error_output = 1'b0;
    buf_we = 1'b0;
    buf_wa = len;
    buf_wd = rx_byte;
    tcrc_en = 1'b0;
    fin_exc = exc;
    // Bytes arriving mid-frame while busy spoil the whole frame
    if (rx_valid && state != ST_IDLE)
      next_drop = 1'b1;
    if (rx_frame_end && state != ST_IDLE)
      next_drop = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (!drop && rx_fault)
          next_rx_bad = 1'b1;
        if (!drop && rx_valid)
        begin
          if (len < 9'(BUF_DEPTH))
          begin
            buf_we = 1'b1;
            next_len = len + 9'h001;
            case (len)
              POS_SADDR: next_saddr = rx_byte;
              POS_FC: next_fc = rx_byte;
              POS_START_HI: next_start[15:8] = rx_byte;
              POS_START_LO: next_start[7:0] = rx_byte;
              POS_CNT_HI: next_cnt[15:8] = rx_byte;
              POS_CNT_LO: next_cnt[7:0] = rx_byte;
              POS_BCNT: next_bcnt = rx_byte;
              default: next_bcnt = bcnt;
            endcase
          end
          else
            next_rx_bad = 1'b1;
        end
        if (rx_frame_end)
        begin
          next_drop = 1'b0;
          if (!drop && len != 9'h000)
            next_state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        next_len = 9'h000;
        next_rx_bad = 1'b0;
        next_state = ST_IDLE;
        next_idx = 8'h00;
        next_ok_cnt = 16'h0000;
        next_first_ok = 16'h0000;
        next_val_bad = 1'b0;
        next_exc = EXC_NONE;
        next_bcast = (saddr == BCAST_ADDR);
        if (fault)
        begin
          // Counted and flagged only; the drive keeps running
          next_comm_error_output = 1'b1;
          if (comm_error_count != {CNT_W{1'b1}})
            next_comm_error_count = comm_error_count + 1'b1;
        end
        else if (for_me)
        begin
          next_state = ST_FINISH;
          case (fc)
            FC_READ:
              if (count_ok(cnt) && len == LEN_READ_QUERY)
                next_state = ST_REQ;
              else
                next_exc = EXC_DATA;
            FC_WRITE:
              if (count_ok(cnt) && bcnt == {cnt[6:0], 1'b0} &&
                  len == LEN_WRITE_HDR + {1'b0, bcnt})
                next_state = ST_REQ;
              else
                next_exc = EXC_DATA;
            FC_LOG:
              if (len != LEN_LOG_QUERY)
                next_exc = EXC_DATA;
            default:
            begin
              next_exc = EXC_FUNC;
              next_log_start = 16'h0000;
              next_log_cnt = 16'h0000;
            end
          endcase
        end
      end
      ST_REQ:
      begin
        next_reg_req = 1'b1;
        next_reg_write = (fc == FC_WRITE);
        next_reg_addr = start + {8'h00, idx};
        next_reg_wdata = {buf_mem[wr_pos], buf_mem[wr_pos + 9'h001]};
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Map answers in the same cycle as the strobe and commits writes itself
        if (reg_ok)
        begin
          if (ok_cnt == 16'h0000)
            next_first_ok = reg_addr;
          next_ok_cnt = ok_cnt + 16'h0001;
          if (reg_write && reg_value_bad)
            next_val_bad = 1'b1;
        end
        next_state = (idx + 8'h01 == cnt[7:0]) ? ST_FINISH : ST_REQ;
        next_idx = idx + 8'h01;
        if (!reg_write)
        begin
          buf_we = 1'b1;
          buf_wa = rd_pos;
          buf_wd = reg_ok ? reg_rdata[15:8] : 8'h00;
          next_rd_lo = reg_ok ? reg_rdata[7:0] : 8'h00;
          next_idx = idx;
          next_state = ST_RD_LO;
        end
      end
      ST_RD_LO:
      begin
        buf_we = 1'b1;
        buf_wa = rd_pos + 9'h001;
        buf_wd = rd_lo;
        next_idx = idx + 8'h01;
        next_state = (idx + 8'h01 == cnt[7:0]) ? ST_FINISH : ST_REQ;
      end
      ST_FINISH:
      begin
        if ((fc == FC_READ || fc == FC_WRITE) && exc == EXC_NONE)
        begin
          if (val_bad)
            fin_exc = EXC_DATA;
          else if (ok_cnt == 16'h0000)
            fin_exc = EXC_ADDR;
          next_log_start = first_ok;
          next_log_cnt = ok_cnt;
        end
        next_exc = fin_exc;
        if (fin_exc != EXC_NONE)
          next_tx_len = LEN_EXC;
        else if (fc == FC_READ)
          next_tx_len = RD_DATA_BASE + {1'b0, cnt[6:0], 1'b0};
        else
          next_tx_len = LEN_ECHO;
        next_tidx = 9'h000;
        next_state = bcast ? ST_IDLE : ST_SEND;
      end
      ST_SEND:
      begin
        if (!tx_valid || tx_ready)
        begin
          if (tidx == tx_len + CRC_BYTES)
          begin
            next_tx_valid = 1'b0;
            next_state = ST_IDLE;
          end
          else
          begin
            next_tx_valid = 1'b1;
            next_tidx = tidx + 9'h001;
            if (tidx < tx_len)
            begin
              next_tx_byte = pick;
              tcrc_en = 1'b1;
            end
            else if (tidx == tx_len)
              next_tx_byte = tx_crc[7:0];
            else
              next_tx_byte = tx_crc[15:8];
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (buf_we)
      buf_mem[buf_wa] <= buf_wd;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      {len, tx_len, tidx} <= '0;
      {drop, rx_bad, bcast, val_bad} <= '0;
      {saddr, fc, bcnt, exc, rd_lo, idx} <= '0;
      {start, cnt, first_ok, ok_cnt, log_start, log_cnt} <= '0;
      {reg_req, reg_write, reg_addr, reg_wdata} <= '0;
      {tx_valid, tx_byte, busy, comm_error_output} <= '0;
      comm_error_count <= '0;
    end
    else
    begin
      state <= next_state;
      len <= next_len;
      tx_len <= next_tx_len;
      tidx <= next_tidx;
      drop <= next_drop;
      rx_bad <= next_rx_bad;
      bcast <= next_bcast;
      val_bad <= next_val_bad;
      saddr <= next_saddr;
      fc <= next_fc;
      bcnt <= next_bcnt;
      exc <= next_exc;
      rd_lo <= next_rd_lo;
      idx <= next_idx;
      start <= next_start;
      cnt <= next_cnt;
      first_ok <= next_first_ok;
      ok_cnt <= next_ok_cnt;
      log_start <= next_log_start;
      log_cnt <= next_log_cnt;
      reg_req <= next_reg_req;
      reg_write <= next_reg_write;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
      busy <= next_busy;
      comm_error_count <= next_comm_error_count;
      comm_error_output <= next_comm_error_output;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_bad_frame;
    state == ST_CHECK && fault;
  endsequence

  sequence s_good_query;
    state == ST_CHECK && !fault && for_me;
  endsequence

  a_silent_on_fault: assert property (s_bad_frame |=> state == ST_IDLE ##1 !tx_valid)
    else $error("bad frame was not discarded");
  a_error_count_step: assert property (s_bad_frame and comm_error_count != {CNT_W{1'b1}}
    |=> comm_error_count == $past(comm_error_count) + 1'b1 && comm_error_output)
    else $error("error count did not advance");
  a_short_frame: assert property (state == ST_CHECK && len < MIN_FRAME |=> comm_error_output)
    else $error("short frame not flagged");
  a_broadcast_mute: assert property (state == ST_FINISH && bcast |=> state == ST_IDLE [*2])
    else $error("reply started for broadcast");
  a_bad_function: assert property (s_good_query and fc != FC_READ && fc != FC_WRITE &&
    fc != FC_LOG |=> exc == EXC_FUNC && log_cnt == 16'h0000 && log_start == 16'h0000)
    else $error("unsupported function handled wrongly");
  a_exc_reply_len: assert property (state == ST_FINISH && fin_exc != EXC_NONE && !bcast
    |=> tx_len == LEN_EXC && state == ST_SEND)
    else $error("error reply length wrong");
  a_no_reg_fail: assert property (state == ST_FINISH && fc == FC_WRITE
    && exc == EXC_NONE && !val_bad && ok_cnt == 16'h0000 |=> exc == EXC_ADDR)
    else $error("missing address error");
  a_partial_ok: assert property (state == ST_FINISH && fc == FC_READ
    && exc == EXC_NONE && ok_cnt != 16'h0000 |=> exc == EXC_NONE && log_cnt == $past(ok_cnt))
    else $error("partial access wrongly refused");
  a_log_capture: assert property (state == ST_FINISH && fc == FC_WRITE && exc == EXC_NONE
    |=> log_start == $past(first_ok) && log_cnt == $past(ok_cnt))
    else $error("access log not captured");
  a_echo_len: assert property (state == ST_FINISH && fc == FC_WRITE && fin_exc == EXC_NONE
    |=> tx_len == LEN_ECHO)
    else $error("write echo length wrong");

endmodule

`default_nettype wire

// file: modbus_master_model.sv
// Behavioural serial-line master: sends query frames and collects reply bytes
`default_nettype none

module modbus_master_model
(
  input wire logic ref_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_fault,
  output logic rx_frame_end,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] bytes_t[$];

  bytes_t rsp;
  // 0: always ready, 1: ready every other cycle, 2: stalled
  int pace = 0;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
    rx_fault = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end

  // ==========================================================
  // Frame check sequence
  function automatic logic [15:0] crc16(input bytes_t b);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  // ==========================================================
  // Query sender; the idle byte line carries the inverse of the last byte
  task automatic send(input bytes_t b, input bit bad_crc, input bit fault);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0000, bad_crc};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i])
    begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_byte = b[i];
      rx_fault = fault && (i == 0);
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_fault = 1'b0;
    rx_byte = ~rx_byte;
    rx_frame_end = 1'b1;
    @(negedge ref_clk);
    rx_frame_end = 1'b0;
  endtask

  // ==========================================================
  // Reply sink
  always @(negedge ref_clk)
    tx_ready <= (pace == 0) ? 1'b1 : (pace == 1) ? ~tx_ready : 1'b0;

  always @(posedge ref_clk)
    if (tx_valid && tx_ready)
      rsp.push_back(tx_byte);
endmodule

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the Modbus slave query engine
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] bytes_t[$];

  logic ref_clk;
  logic rst_b;
  logic [7:0] station_addr;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_fault;
  logic rx_frame_end;
  logic reg_req;
  logic reg_write;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_ok;
  logic reg_value_bad;
  logic [15:0] reg_rdata;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_ready;
  logic busy;
  logic [15:0] comm_error_count;
  logic comm_error_output;
  int errors = 0;
  int checked = 0;
  int pulses = 0;
  int writes = 0;
  logic [31:0] wlog;

  modbus_slave_access_log modbus_slave_access_log_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .station_addr(station_addr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_fault(rx_fault), .rx_frame_end(rx_frame_end), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ok(reg_ok),
    .reg_value_bad(reg_value_bad), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .busy(busy),
    .comm_error_count(comm_error_count), .comm_error_output(comm_error_output));

  modbus_master_model master_inst (.ref_clk(ref_clk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_fault(rx_fault), .rx_frame_end(rx_frame_end),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

  // ==========================================================
  // Register map: 03ee..03f5 exist, ffff is out of range
  assign reg_ok = (reg_addr >= 16'h03ee) && (reg_addr <= 16'h03f5);
  assign reg_value_bad = reg_write && (reg_wdata == 16'hffff);
  assign reg_rdata = reg_addr ^ 16'h5a00;

  always @(posedge ref_clk)
  begin
    if (comm_error_output === 1'b1)
      pulses <= pulses + 1;
    if (reg_req === 1'b1 && reg_write === 1'b1)
    begin
      writes <= writes + 1;
      wlog <= {reg_addr, reg_wdata};
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic close_out;
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input bytes_t q, input bit bad = 1'b0, input bit fault = 1'b0);
    master_inst.rsp.delete();
    master_inst.send(q, bad, fault);
    repeat (4) @(negedge ref_clk);
    for (int n = 0; n < 3000 && busy !== 1'b0; n++)
      @(negedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic exp_rsp(input bytes_t q);
    logic [15:0] c;
    c = master_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    cmp(16'(master_inst.rsp.size()), 16'(q.size()));
    foreach (q[i])
      if (i < master_inst.rsp.size())
        cmp({8'h00, master_inst.rsp[i]}, {8'h00, q[i]});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_write_echo;
    run({8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a});
    exp_rsp({8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02});
    cmp({master_inst.rsp[6], master_inst.rsp[7]}, 16'h2261);
    cmp(wlog[31:16], 16'h03ef);
    cmp(wlog[15:0], 16'h000a);
    run({8'h19, 8'h46});
    exp_rsp({8'h19, 8'h46, 8'h03, 8'hee, 8'h00, 8'h02});
  endtask

  task automatic t_read_partial;
    run({8'h19, 8'h03, 8'h03, 8'hf4, 8'h00, 8'h04});
    exp_rsp({8'h19, 8'h03, 8'h08, 8'h59, 8'hf4, 8'h59, 8'hf5, 8'h00, 8'h00, 8'h00,
      8'h00});
    run({8'h19, 8'h46});
    exp_rsp({8'h19, 8'h46, 8'h03, 8'hf4, 8'h00, 8'h02});
  endtask

  task automatic t_exceptions;
    run({8'h19, 8'h03, 8'h01, 8'h00, 8'h00, 8'h02});
    exp_rsp({8'h19, 8'h83, 8'h02});
    run({8'h19, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34});
    exp_rsp({8'h19, 8'h90, 8'h02});
    run({8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h01, 8'h02, 8'hff, 8'hff});
    exp_rsp({8'h19, 8'h90, 8'h03});
    run({8'h19, 8'h03, 8'h03, 8'hee, 8'h00, 8'h00});
    exp_rsp({8'h19, 8'h83, 8'h03});
    run({8'h19, 8'h46, 8'h00});
    exp_rsp({8'h19, 8'hc6, 8'h03});
    run({8'h19, 8'h46});
    exp_rsp({8'h19, 8'h46, 8'h03, 8'hee, 8'h00, 8'h01});
    run({8'h19, 8'h07, 8'h00, 8'h00});
    exp_rsp({8'h19, 8'h87, 8'h01});
    run({8'h19, 8'h46});
    exp_rsp({8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
  endtask

  // Second query lands while the reply is stalled and must vanish
  task automatic t_busy;
    logic [15:0] e0;
    e0 = comm_error_count;
    master_inst.rsp.delete();
    master_inst.pace = 2;
    master_inst.send({8'h19, 8'h46}, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk);
    cmp({15'h0000, busy}, 16'h0001);
    master_inst.send({8'h19, 8'h07, 8'h00, 8'h00}, 1'b0, 1'b0);
    master_inst.pace = 1;
    for (int n = 0; n < 3000 && busy !== 1'b0; n++)
      @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    master_inst.pace = 0;
    exp_rsp({8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
    cmp(comm_error_count, e0);
  endtask

  task automatic t_silent;
    logic [15:0] e0;
    int p0;
    e0 = comm_error_count;
    p0 = pulses;
    run({8'h19, 8'h46}, 1'b1);
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    run({8'h19});
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    run({8'h19, 8'h46}, 1'b0, 1'b1);
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    cmp(comm_error_count, e0 + 16'h0003);
    cmp(16'(pulses - p0), 16'h0003);
    run({8'h22, 8'h46});
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    run({8'h19, 8'h46});
    exp_rsp({8'h19, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
  endtask

  // Broadcasts carry other functions only; the log query always names a station
  task automatic t_broadcast;
    int w0;
    w0 = writes;
    run({8'h00, 8'h07, 8'h00, 8'h00});
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    run({8'h00, 8'h10, 8'h03, 8'hef, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34});
    cmp(16'(master_inst.rsp.size()), 16'h0000);
    cmp(16'(writes - w0), 16'h0001);
    cmp(wlog[31:16], 16'h03ef);
    cmp(wlog[15:0], 16'h1234);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst_b = 1'b0;
    station_addr = 8'h19;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    cmp(comm_error_count, 16'h0000);
    cmp({15'h0000, tx_valid}, 16'h0000);
    t_write_echo();
    t_read_partial();
    t_exceptions();
    t_busy();
    t_silent();
    t_broadcast();
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    close_out();
  end
endmodule

`default_nettype wire
